// ==== core/pcm_monitor.sv ====
// Contract
// [RULE1] Bottom rise: top high, after run-down fall.
// [RULE2] Bottom must be low when run-down falls.
// [RULE3] Demand high or risen before run-down falls.
// [RULE4] Stroke order top, demand, run-down, bottom.
// [RULE5] Upstroke only on first bottom rise.
// [RULE6] End: top and bottom fall any order.
// [RULE7] Zero to two setting allows 0-2 pulses.
// [RULE8] Zero to two: run-down fall not required.
// [RULE9] Ordering violation drops permit, raises sequence fault.
// [RULE10] Fault holds permit low, restart pending high.
// [RULE11] Run-down left while stopped sets overrun fault.
// [RULE12] Any fault forces top flag, upstroke low.
// [RULE13] Bottom high at start blocks until top falls.
// [RULE14] Low permit input forces outputs inactive only; code drops permit, top flag, upstroke, keeps faults, pauses checks.
// [RULE15] Inputs sampled each cycle, edges versus previous.
`timescale 1ns/1ps
`default_nettype none
module pcm_monitor
	import pcm_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic resetn_in,
	// Cam contacts and stroke demand, from pins.
	input wire pcm_cams_s cams_in,
	// Configuration and control.
	input wire pcm_bottom_mode_e bottom_pulse_count_setting_in,
	input wire logic permit_in,
	input wire logic restart_in,
	// Results.
	output logic permit_out,
	output logic top_flag_out,
	output logic upstroke_out,
	output logic restart_pending_out,
	output logic sequence_fault_out,
	output logic overrun_fault_out,
	output logic any_fault_out
);

	// ==========================================================================
	// Input synchronisers and previous samples.
	// ==========================================================================
	pcm_cams_s meta_r, meta_nxt;
	pcm_cams_s cur_r, cur_nxt;
	pcm_cams_s prev_r, prev_nxt;
	logic permit_meta_r, permit_meta_nxt, permit_sync_r, permit_sync_nxt;
	logic restart_meta_r, restart_meta_nxt, restart_sync_r, restart_sync_nxt;
	logic restart_prev_r, restart_prev_nxt;

	always_comb begin
		meta_nxt = cams_in;
		cur_nxt = meta_r;
		prev_nxt = cur_r; // RULE15
		permit_meta_nxt = permit_in;
		permit_sync_nxt = permit_meta_r;
		restart_meta_nxt = restart_in;
		restart_sync_nxt = restart_meta_r;
		restart_prev_nxt = restart_sync_r;
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			meta_r <= PCM_CAMS_RESET;
			cur_r <= PCM_CAMS_RESET;
			prev_r <= PCM_CAMS_RESET;
			permit_meta_r <= 1'h0;
			permit_sync_r <= 1'h0;
			restart_meta_r <= 1'h0;
			restart_sync_r <= 1'h0;
			restart_prev_r <= 1'h0;
		end else begin
			meta_r <= meta_nxt;
			cur_r <= cur_nxt;
			prev_r <= prev_nxt;
			permit_meta_r <= permit_meta_nxt;
			permit_sync_r <= permit_sync_nxt;
			restart_meta_r <= restart_meta_nxt;
			restart_sync_r <= restart_sync_nxt;
			restart_prev_r <= restart_prev_nxt;
		end
	end

	// Edge detection on the second-stage samples only.
	logic top_rise, top_fall, bot_rise, bot_fall, rd_fall, rd_rise, dem_rise, restart_fall;
	assign top_rise = cur_r.top_cam_contact & ~prev_r.top_cam_contact; // RULE15
	assign top_fall = ~cur_r.top_cam_contact & prev_r.top_cam_contact;
	assign bot_rise = cur_r.bottom_cam_contact & ~prev_r.bottom_cam_contact;
	assign bot_fall = ~cur_r.bottom_cam_contact & prev_r.bottom_cam_contact;
	assign rd_fall = ~cur_r.rundown_cam_contact & prev_r.rundown_cam_contact;
	assign rd_rise = cur_r.rundown_cam_contact & ~prev_r.rundown_cam_contact;
	assign dem_rise = cur_r.stroke_demand & ~prev_r.stroke_demand;
	// A restart is taken on the falling edge of the restart pulse.
	assign restart_fall = ~restart_sync_r & restart_prev_r;

	// ==========================================================================
	// Stroke sequencer.
	// ==========================================================================
	pcm_state_e state_r, state_nxt;
	logic seq_fault_r, seq_fault_nxt;
	logic ovr_fault_r, ovr_fault_nxt;
	logic demand_seen_r, demand_seen_nxt;
	logic rd_fell_r, rd_fell_nxt;
	logic up_done_r, up_done_nxt;
	logic up_r, up_nxt;
	logic bot_block_r, bot_block_nxt;
	logic first_r, first_nxt;
	logic bad_seq, bad_ovr, end_stroke, bot_blocked;

	always_comb begin
		state_nxt = state_r;
		seq_fault_nxt = seq_fault_r;
		ovr_fault_nxt = ovr_fault_r;
		demand_seen_nxt = demand_seen_r;
		rd_fell_nxt = rd_fell_r;
		up_done_nxt = up_done_r;
		up_nxt = up_r;
		bot_block_nxt = bot_block_r;
		// Until the synchronised permit is up the cam samples may still hold reset values,
		// so the start of monitoring stays open until then.
		first_nxt = first_r && !permit_sync_r;
		bad_seq = 1'h0;
		bad_ovr = 1'h0;
		end_stroke = 1'h0;
		bot_blocked = bot_block_r || (first_r && cur_r.bottom_cam_contact); // RULE13
		// Bottom already high when monitoring begins: ignore it until the top cam falls.
		if (first_r && cur_r.bottom_cam_contact) begin
			bot_block_nxt = 1'h1; // RULE13
		end
		if (state_r != PCM_ST_FAULT && permit_sync_r) begin
			// Run-down leaving without demand means the press overran its stop.
			if (rd_fall && !cur_r.stroke_demand && !demand_seen_r) begin
				bad_ovr = 1'h1; // RULE3 RULE11
			end
			if (rd_fall && cur_r.bottom_cam_contact && !bot_blocked) begin
				bad_seq = 1'h1; // RULE2
			end
			if (rd_fall && state_r != PCM_ST_TOP && state_r != PCM_ST_RUNDOWN) begin
				bad_seq = 1'h1; // RULE4
			end
			if (bot_rise && !bot_blocked) begin
				if (!cur_r.top_cam_contact) begin
					bad_seq = 1'h1; // RULE1 RULE8
				end else if (!rd_fell_r
						&& bottom_pulse_count_setting_in == PCM_BOTTOM_ONE) begin
					bad_seq = 1'h1; // RULE1 RULE4
				end else if (up_done_r
						&& bottom_pulse_count_setting_in == PCM_BOTTOM_ONE) begin
					bad_seq = 1'h1; // RULE7
				end
			end
			if (rd_fall) begin
				rd_fell_nxt = 1'h1;
			end
			if (dem_rise && state_r == PCM_ST_TOP) begin
				demand_seen_nxt = 1'h1; // RULE3
			end
			case (state_r)
				PCM_ST_IDLE: begin
					if (top_rise) begin
						state_nxt = PCM_ST_TOP; // RULE4
						demand_seen_nxt = 1'h0;
						rd_fell_nxt = 1'h0;
						up_done_nxt = 1'h0;
					end
				end
				PCM_ST_TOP: begin
					if (rd_fall) begin
						state_nxt = PCM_ST_RUNDOWN;
					end
				end
				PCM_ST_RUNDOWN, PCM_ST_BOTTOM: begin
					if (bot_rise && !bot_blocked) begin
						state_nxt = PCM_ST_BOTTOM;
					end
					if (top_fall) begin
						end_stroke = 1'h1; // RULE6
					end
				end
				default: begin
					state_nxt = PCM_ST_IDLE;
				end
			endcase
			// The zero to two setting lets a bottom pulse come before run-down falls,
			// so the upstroke is raised from the top phase as well.
			if (state_r != PCM_ST_IDLE && bot_rise && !bot_blocked) begin
				if (!up_done_r) begin
					up_nxt = 1'h1; // RULE5
				end
				up_done_nxt = 1'h1; // RULE5
			end
			if (top_fall || bot_fall) begin
				up_nxt = 1'h0; // RULE6
			end
			// No bottom pulse at all is fine in the zero to two setting.
			if (state_r == PCM_ST_TOP && top_fall) begin
				end_stroke = 1'h1; // RULE7
			end
			if (end_stroke) begin
				state_nxt = PCM_ST_IDLE;
				up_nxt = 1'h0;
			end
			if (top_fall) begin
				bot_block_nxt = 1'h0; // RULE13
			end
		end
		if (!permit_sync_r) begin
			up_nxt = 1'h0;
		end
		if (bad_seq) begin
			seq_fault_nxt = 1'h1; // RULE9
		end
		if (bad_ovr) begin
			ovr_fault_nxt = 1'h1; // RULE11
		end
		if (bad_seq || bad_ovr) begin
			state_nxt = PCM_ST_FAULT;
			up_nxt = 1'h0; // RULE12
		end
		if (state_r == PCM_ST_FAULT && restart_fall) begin
			seq_fault_nxt = 1'h0; // RULE10
			ovr_fault_nxt = 1'h0; // RULE11
			state_nxt = PCM_ST_IDLE;
			first_nxt = 1'h1;
			bot_block_nxt = 1'h0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_r <= PCM_ST_IDLE;
			seq_fault_r <= 1'h0;
			ovr_fault_r <= 1'h0;
			demand_seen_r <= 1'h0;
			rd_fell_r <= 1'h0;
			up_done_r <= 1'h0;
			up_r <= 1'h0;
			bot_block_r <= 1'h0;
			first_r <= 1'h1;
		end else begin
			state_r <= state_nxt;
			seq_fault_r <= seq_fault_nxt;
			ovr_fault_r <= ovr_fault_nxt;
			demand_seen_r <= demand_seen_nxt;
			rd_fell_r <= rd_fell_nxt;
			up_done_r <= up_done_nxt;
			up_r <= up_nxt;
			bot_block_r <= bot_block_nxt;
			first_r <= first_nxt;
		end
	end

	// ==========================================================================
	// Outputs.
	// ==========================================================================
	logic any_fault;
	assign any_fault = seq_fault_r | ovr_fault_r;
	assign permit_out = permit_sync_r & ~any_fault; // RULE9 RULE10 RULE14
	assign top_flag_out = permit_sync_r & ~any_fault & cur_r.top_cam_contact; // RULE12 RULE14
	assign upstroke_out = up_r & permit_sync_r & ~any_fault; // RULE12 RULE14
	assign restart_pending_out = any_fault; // RULE10
	assign sequence_fault_out = seq_fault_r;
	assign overrun_fault_out = ovr_fault_r;
	assign any_fault_out = any_fault; // RULE10

endmodule : pcm_monitor
`default_nettype wire

// ==== core/pcm_pkg.sv ====
package pcm_pkg;

	// ==========================================================================
	// Bottom pulse count settings.
	// ==========================================================================
	typedef enum logic [0:0] {
		PCM_BOTTOM_ONE = 1'h0,
		PCM_BOTTOM_ZERO_TO_TWO = 1'h1
	} pcm_bottom_mode_e;

	// ==========================================================================
	// Stroke phases, Gray coded along the normal stroke.
	// ==========================================================================
	typedef enum logic [2:0] {
		PCM_ST_IDLE = 3'h0,
		PCM_ST_TOP = 3'h1,
		PCM_ST_RUNDOWN = 3'h3,
		PCM_ST_BOTTOM = 3'h2,
		PCM_ST_FAULT = 3'h6
	} pcm_state_e;

	// ==========================================================================
	// Cam and demand inputs travel together.
	// ==========================================================================
	typedef struct packed {
		logic top_cam_contact;
		logic bottom_cam_contact;
		logic rundown_cam_contact;
		logic stroke_demand;
	} pcm_cams_s;

	localparam pcm_cams_s PCM_CAMS_RESET = '{
		top_cam_contact: 1'h0,
		bottom_cam_contact: 1'h0,
		rundown_cam_contact: 1'h1,
		stroke_demand: 1'h0
	};

endpackage : pcm_pkg

// ==== dv/pcm_cam_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// Cam switches: one fixed contact pattern for each stroke phase.
module pcm_cam_model
	import pcm_pkg::*;
(
	// Phase chosen by the bench.
	input wire logic [2:0] phase_in,
	// Contacts.
	output var pcm_cams_s cams_out
);
	// Phase 6 leaves the run-down cam without demand, on purpose.
	always_comb begin
		case (phase_in)
			3'h1: cams_out = 4'hA;
			3'h2: cams_out = 4'hB;
			3'h3: cams_out = 4'h9;
			3'h4: cams_out = 4'hD;
			3'h5: cams_out = 4'hF;
			3'h6: cams_out = 4'h8;
			// Phase 7 drops the top cam while the bottom cam is still made.
			3'h7: cams_out = 4'h6;
			default: cams_out = PCM_CAMS_RESET;
		endcase
	end
endmodule : pcm_cam_model
`default_nettype wire

// ==== dv/pcm_monitor_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// Port checker.
module pcm_monitor_chk
	import pcm_pkg::*;
(
	// Clock, reset and inputs.
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire pcm_cams_s cams_in,
	input wire logic permit_in,
	input wire logic restart_in,
	// Results.
	input wire logic permit_out,
	input wire logic top_flag_out,
	input wire logic upstroke_out,
	input wire logic restart_pending_out,
	input wire logic sequence_fault_out,
	input wire logic overrun_fault_out,
	input wire logic any_fault_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);
	wire logic flt = sequence_fault_out || overrun_fault_out;
	chk_fault_outputs: assert property (flt |-> !permit_out && restart_pending_out && any_fault_out)
		else $error("fault outputs wrong");
	chk_fault_clears_flags: assert property (any_fault_out |-> !top_flag_out && !upstroke_out)
		else $error("flags high in fault");
	chk_permit_gates: assert property (!permit_in [*3] |=> !permit_out && !top_flag_out && !upstroke_out)
		else $error("outputs active without permit");
	chk_permit_follows: assert property (permit_in [*3] ##1 !flt |-> permit_out)
		else $error("permit missing");
	chk_seq_fault_held: assert property (!restart_in [*8] ##0 sequence_fault_out |=> sequence_fault_out)
		else $error("sequence fault dropped");
	chk_over_fault_held: assert property (!restart_in [*8] ##0 overrun_fault_out |=> overrun_fault_out)
		else $error("overrun fault dropped");
	chk_upstroke_cause: assert property ($rose(upstroke_out) |-> $past(cams_in.bottom_cam_contact, 2))
		else $error("upstroke without bottom cam");
	chk_fault_release: assert property ($fell(any_fault_out) |-> $past(restart_in, 5) || $past(restart_in, 6))
		else $error("fault cleared without restart");
	cov_seq: cover property ($rose(sequence_fault_out));
	cov_over: cover property ($rose(overrun_fault_out));
	cov_up: cover property ($rose(upstroke_out));
endmodule : pcm_monitor_chk
bind pcm_monitor pcm_monitor_chk chk_u (.clk_in(clk_in), .resetn_in(resetn_in), .cams_in(cams_in),
	.permit_in(permit_in), .restart_in(restart_in), .permit_out(permit_out),
	.top_flag_out(top_flag_out), .upstroke_out(upstroke_out),
	.restart_pending_out(restart_pending_out), .sequence_fault_out(sequence_fault_out),
	.overrun_fault_out(overrun_fault_out), .any_fault_out(any_fault_out));
`default_nettype wire

// ==== dv/tb_press_cam_sequence_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench: cam phases in, packed results compared.
module tb_press_cam_sequence_monitor;
	import pcm_pkg::*;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
	logic clk_in = 1'h0;
	logic resetn_in = 1'h0;
	logic permit_in = 1'h0;
	logic restart_in = 1'h0;
	logic [2:0] phase = 3'h0;
	pcm_bottom_mode_e mode = PCM_BOTTOM_ONE;
	pcm_cams_s cams;
	logic [6:0] outs;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	pcm_cam_model m_u (.phase_in(phase), .cams_out(cams));
	pcm_monitor dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .cams_in(cams),
		.bottom_pulse_count_setting_in(mode), .permit_in(permit_in), .restart_in(restart_in),
		.permit_out(outs[6]), .top_flag_out(outs[5]), .upstroke_out(outs[4]),
		.restart_pending_out(outs[3]), .sequence_fault_out(outs[2]),
		.overrun_fault_out(outs[1]), .any_fault_out(outs[0]));
	initial forever #2.5 clk_in = ~clk_in;
	// ====
	// Tasks.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	// Five cycles cover the two-stage synchroniser, edge compare and result register.
	task automatic settle();
		repeat (5) @(posedge clk_in);
		#1;
	endtask : settle
	task automatic go(input logic [2:0] p);
		@(posedge clk_in);
		phase <= p;
		settle();
	endtask : go
	task automatic permit(input logic v);
		@(posedge clk_in);
		permit_in <= v;
		settle();
	endtask : permit
	task automatic check(input string n, input logic [6:0] e);
		`CHK(n, e, outs)
	endtask : check
	// Cams take the given phase first, so the restart meets a known start condition.
	task automatic restart(input logic [2:0] p);
		go(p);
		@(posedge clk_in);
		restart_in <= 1'h1;
		repeat (6) @(posedge clk_in);
		restart_in <= 1'h0;
		repeat (8) @(posedge clk_in);
		#1;
		check("restart", 7'h40);
	endtask : restart
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	// ====
	// Tests.
	initial begin
		repeat (12) @(posedge clk_in);
		resetn_in <= 1'h1;
		permit(1'h1);
		check("idle", 7'h40);
		go(3'h1);
		check("top", 7'h60);
		permit(1'h0);
		check("no permit", 7'h00);
		permit(1'h1);
		go(3'h2);
		go(3'h3);
		check("run-down", 7'h60);
		go(3'h4);
		check("upstroke", 7'h70);
		go(3'h5);
		go(3'h2);
		check("bottom fell", 7'h60);
		go(3'h0);
		check("end", 7'h40);
		for (int i = 1; i < 6; i++) go(i[2:0]);
		go(3'h7);
		check("top fell first", 7'h40);
		go(3'h0);
		check("bottom fell last", 7'h40);
		$display("test single stroke done");
		@(posedge clk_in);
		mode <= PCM_BOTTOM_ZERO_TO_TWO;
		for (int i = 1; i < 6; i++) go(i[2:0]);
		go(3'h2);
		go(3'h5);
		check("second bottom", 7'h60);
		go(3'h2);
		go(3'h0);
		check("two pulses", 7'h40);
		go(3'h1);
		go(3'h2);
		go(3'h3);
		go(3'h2);
		go(3'h0);
		check("no bottom", 7'h40);
		go(3'h1);
		go(3'h2);
		go(3'h5);
		check("early bottom", 7'h70);
		go(3'h4);
		check("bottom at run-down", 7'h0D);
		permit(1'h0);
		check("fault kept", 7'h0D);
		permit(1'h1);
		restart(3'h0);
		$display("test zero to two done");
		@(posedge clk_in);
		mode <= PCM_BOTTOM_ONE;
		for (int i = 1; i < 6; i++) go(i[2:0]);
		go(3'h2);
		go(3'h5);
		check("extra bottom", 7'h0D);
		restart(3'h0);
		go(3'h1);
		go(3'h2);
		go(3'h5);
		check("bottom first", 7'h0D);
		restart(3'h0);
		go(3'h1);
		go(3'h6);
		check("overrun", 7'h0B);
		restart(3'h7);
		go(3'h0);
		go(3'h7);
		check("bottom held at start", 7'h40);
		go(3'h0);
		for (int i = 1; i < 5; i++) go(i[2:0]);
		check("bottom ignored", 7'h60);
		go(3'h0);
		$display("test faults done");
		tally_and_finish();
	end
endmodule : tb_press_cam_sequence_monitor
`default_nettype wire
